// [include/tws_pkg.sv]
// Constants and types shared by the two-wire serial memory target
// Overview of operation
// - 64 KiB array as 512 pages of 128
// - Sixteen-bit word address selects any byte
// - Sample on clock rise, change after fall
// - Data line open-drain: pull low or release
// - Respond only when select bits match straps
// - Open select strap reads as low
// - Write-protect high when the stop is handled blocks that page write
// - Open write-protect reads low, writes enabled
// - Page write up to 128 bytes, partial allowed
// - Self-timed programming ends within 5 ms
// - Start/stop are data edges while clock high
// - Eight-bit words, acknowledge low on ninth pulse
// - Address word: 1010, select bits, direction bit
// - Page write wraps low seven address bits
package tws_pkg;

    // -------------------------------------------------------------
    // Array geometry
    // -------------------------------------------------------------
    localparam int unsigned PAGE_BYTES = 128;
    localparam int unsigned PAGE_COUNT = 512;
    localparam int unsigned MEM_BYTES = PAGE_BYTES * PAGE_COUNT;
    localparam logic [7:0] COPY_END = 8'h80; // Copy index past last byte

    // -------------------------------------------------------------
    // Protocol constants
    // -------------------------------------------------------------
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha; // Fixed one-zero-one-zero
    localparam logic [3:0] BIT_LAST = 4'h7; // Count before eighth rise
    localparam logic [3:0] BIT_ACK = 4'h8; // Count before ninth rise

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned PROG_TIME_MS = 5;
    // Longest time, so the count rounds down
    localparam int unsigned PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned TIMER_W = 18;

    // -------------------------------------------------------------
    // Buffering
    // -------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned FIFO_W = 24;

    // -------------------------------------------------------------
    // Types and reset values
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_AHI = 3'b010,
        ST_ALO = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101
    } tws_link_st_e;

    typedef struct packed {
        logic [8:0] page;
        logic [6:0] offs;
        logic [7:0] data;
    } tws_wr_entry_s;

    typedef struct packed {
        tws_link_st_e st;
        logic [3:0] bit_cnt;
        logic [6:0] shreg;
        logic [7:0] tx;
        logic ack_en;
        logic [15:0] addr;
        logic start_seen;
        logic req_tgl;
        logic req_wr;
        logic [15:0] req_addr;
        logic [7:0] req_data;
    } tws_link_s;

    typedef struct packed {
        logic req_seen;
        logic stop_last;
        logic [15:0] rd_addr;
        logic stop_pend;
        logic busy;
        logic [TIMER_W-1:0] timer;
        logic [7:0] copy_idx;
        logic [8:0] page;
        logic [PAGE_BYTES-1:0] mask;
    } tws_core_s;

    localparam tws_link_s LINK_RESET = '0;
    localparam tws_core_s CORE_RESET = '0;

endpackage

// [include/tws_fifo_if.sv]
// Valid/ready carrier between the receiver and the write buffer FIFO
`timescale 1ns/10ps
interface tws_fifo_if #(parameter int unsigned WIDTH = 24);
    logic push_valid; // Filling side offers a word
    logic push_ready; // FIFO has room
    logic [WIDTH-1:0] push_data;
    logic pop_valid; // FIFO holds a word
    logic pop_ready; // Draining side takes it
    logic [WIDTH-1:0] pop_data;
    modport src (output push_valid, push_data, input push_ready);
    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport snk (input pop_valid, pop_data, output pop_ready);
endinterface // tws_fifo_if

// [rtl/tws_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module tws_sync #(parameter int unsigned WIDTH = 1) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1; // Metastable stage, read only by s2
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } tws_sync_s;

    tws_sync_s sync_reg;
    tws_sync_s sync_next;

    // Output moves only once the last two stages agree
    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = d_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        sync_next.q = (sync_reg.s2 & ~(sync_reg.s2 ^ sync_reg.s3)) |
                      (sync_reg.q & (sync_reg.s2 ^ sync_reg.s3));
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q_out = sync_reg.q;

endmodule // tws_sync

// [rtl/tws_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tws_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Both sides of the buffer
    tws_fifo_if.fifo port
);

    localparam int unsigned PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0] count;
    } tws_fifo_s;

    tws_fifo_s fifo_reg;
    tws_fifo_s fifo_next;
    logic [WIDTH-1:0] store [DEPTH]; // Entry storage, no reset needed
    logic do_push;
    logic do_pop;

    assign port.push_ready = (fifo_reg.count != FULL_COUNT);
    assign port.pop_valid = (fifo_reg.count != '0);
    assign port.pop_data = store[fifo_reg.rptr];
    assign do_push = port.push_valid && port.push_ready;
    assign do_pop = port.pop_valid && port.pop_ready;

    // Pointer and count update; pointers wrap on the power-of-two depth
    always_comb begin
        fifo_next = fifo_reg;
        if (do_push) begin
            fifo_next.wptr = fifo_reg.wptr + 1'b1;
        end
        if (do_pop) begin
            fifo_next.rptr = fifo_reg.rptr + 1'b1;
        end
        if (do_push && !do_pop) begin
            fifo_next.count = fifo_reg.count + 1'b1;
        end else if (do_pop && !do_push) begin
            fifo_next.count = fifo_reg.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    // Entry write
    always_ff @(posedge clk_in) begin
        if (do_push) begin
            store[fifo_reg.wptr] <= port.push_data;
        end
    end

endmodule // tws_fifo

// [rtl/tws_target.sv]
// Two-wire serial memory target: link engine, write buffer and array
`timescale 1ns/10ps
module tws_target
    import tws_pkg::*;
#(
    parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
    // System clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    // Straps
    input wire logic [2:0] device_select_inputs_in,
    input wire logic write_protect_in,
    // Status
    output logic program_busy_out
);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    tws_link_s link_reg; // Link state, clocked by the bus clock
    tws_link_s link_next;
    tws_core_s core_reg; // Core state, clocked by clock_in
    tws_core_s core_next;
    logic start_tgl_reg; // Flips on every start condition
    logic stop_tgl_reg; // Flips on every stop condition
    logic sda_drive_reg; // High while pulling the data line low
    logic drive_low; // Drive wanted for the coming low phase
    logic [7:0] rx_byte; // Byte completed at the eighth rise
    logic req_idle; // Previous request taken by the core
    logic [4:0] link_sync; // {select, busy, ack} in link domain
    logic [2:0] sel_sync;
    logic busy_sync;
    logic ack_sync;
    logic [2:0] core_sync; // {request, stop, protect} in core domain
    logic req_sync;
    logic stop_sync;
    logic wp_sync;
    logic req_pending; // Request toggle not yet taken
    logic stop_evt; // One-cycle pulse for each stop
    logic pop_take; // Buffered byte moves to the page latch
    logic copy_wr; // Latched byte written to the array
    tws_wr_entry_s push_entry;
    tws_wr_entry_s pop_entry;
    logic [7:0] mem_array [MEM_BYTES]; // Nonvolatile array
    logic [7:0] page_latch [PAGE_BYTES]; // Bytes awaiting programming
    logic [7:0] rd_byte_reg; // Array byte at the read pointer

    tws_fifo_if #(.WIDTH(FIFO_W)) fifo_bus ();

    // -------------------------------------------------------------
    // Start and stop detection
    // -------------------------------------------------------------
    // Data edges while the clock is high mark frame limits; the
    // start toggle is read at the next clock rise, which comes a
    // full hold plus low time later, so it is long settled there.
    always_ff @(negedge sda_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    // Stop is an event for the core domain, sent as a toggle
    always_ff @(posedge sda_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    // -------------------------------------------------------------
    // Crossings into the link domain
    // -------------------------------------------------------------
    // Straps, busy level and request acknowledge, three stages each
    tws_sync #(.WIDTH(5)) u_link_sync (
        .clk_in(scl_in),
        .rst_n_in(rst_n_in),
        .d_in({device_select_inputs_in, core_reg.busy | core_reg.stop_pend,
               core_reg.req_seen}),
        .q_out(link_sync)
    );

    assign sel_sync = link_sync[4:2];
    assign busy_sync = link_sync[1];
    assign ack_sync = link_sync[0];

    // -------------------------------------------------------------
    // Link engine
    // -------------------------------------------------------------
    assign rx_byte = {link_reg.shreg, sda_in};
    assign req_idle = (link_reg.req_tgl == ack_sync);

    // Bit counting, byte decode and acknowledge decisions
    always_comb begin
        link_next = link_reg;
        if (start_tgl_reg != link_reg.start_seen) begin
            // First rise of a new frame carries the top address bit
            link_next.start_seen = start_tgl_reg;
            link_next.st = ST_DEV;
            link_next.bit_cnt = 4'h1;
            link_next.shreg = {6'h00, sda_in};
            link_next.ack_en = 1'b0;
        end else if (link_reg.bit_cnt == BIT_ACK) begin
            // Ninth rise: acknowledge slot ends
            link_next.bit_cnt = 4'h0;
            link_next.ack_en = 1'b0;
            if (link_reg.st == ST_RDATA) begin
                if (link_reg.ack_en || !sda_in) begin
                    // Load next byte; reads wrap over the whole array
                    link_next.tx = rd_byte_reg;
                    link_next.addr = link_reg.addr + 16'h0001;
                    link_next.req_tgl = ~link_reg.req_tgl;
                    link_next.req_wr = 1'b0;
                    link_next.req_addr = link_reg.addr + 16'h0001;
                end else begin
                    // Master declined: wait for stop
                    link_next.st = ST_IDLE;
                end
            end
        end else begin
            link_next.bit_cnt = link_reg.bit_cnt + 4'h1;
            link_next.shreg = rx_byte[6:0];
            link_next.tx = {link_reg.tx[6:0], 1'b1};
            if (link_reg.bit_cnt == BIT_LAST) begin
                // Eighth rise: a whole word is in
                unique case (link_reg.st)
                    ST_IDLE: begin
                        link_next.st = ST_IDLE;
                    end
                    ST_DEV: begin
                        // Pads pull open straps low, so they match 0
                        if (rx_byte[7:4] == DEV_TYPE_CODE &&
                            rx_byte[3:1] == sel_sync &&
                            !busy_sync) begin
                            link_next.ack_en = 1'b1;
                            link_next.st = rx_byte[0] ? ST_RDATA : ST_AHI;
                        end else begin
                            link_next.st = ST_IDLE;
                        end
                    end
                    ST_AHI: begin
                        link_next.addr[15:8] = rx_byte;
                        link_next.ack_en = 1'b1;
                        link_next.st = ST_ALO;
                    end
                    ST_ALO: begin
                        if (req_idle) begin
                            // Word address also primes the read pointer
                            link_next.addr[7:0] = rx_byte;
                            link_next.ack_en = 1'b1;
                            link_next.st = ST_WDATA;
                            link_next.req_tgl = ~link_reg.req_tgl;
                            link_next.req_wr = 1'b0;
                            link_next.req_addr = {link_reg.addr[15:8],
                                                  rx_byte};
                        end else begin
                            link_next.st = ST_IDLE;
                        end
                    end
                    ST_WDATA: begin
                        // A byte the core cannot yet take is refused
                        if (req_idle) begin
                            link_next.ack_en = 1'b1;
                            link_next.req_tgl = ~link_reg.req_tgl;
                            link_next.req_wr = 1'b1;
                            link_next.req_addr = link_reg.addr;
                            link_next.req_data = rx_byte;
                            link_next.addr[6:0] = link_reg.addr[6:0] +
                                                  7'h01;
                        end else begin
                            link_next.st = ST_IDLE;
                        end
                    end
                    ST_RDATA: begin
                        link_next.st = ST_RDATA;
                    end
                    default: begin
                        link_next.st = ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Data is taken on the rising bus clock edge
    always_ff @(posedge scl_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_reg <= LINK_RESET;
        end else begin
            link_reg <= link_next;
        end
    end

    // Acknowledge or a zero read bit pulls the line in the low phase
    assign drive_low = link_reg.ack_en |
                       (link_reg.st == ST_RDATA &&
                        link_reg.bit_cnt != BIT_ACK && !link_reg.tx[7]);

    // Outgoing data changes only after the falling clock edge
    always_ff @(negedge scl_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_drive_reg <= 1'b0;
        end else begin
            sda_drive_reg <= drive_low;
        end
    end

    // Open drain: the driven level is always low, else released
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~sda_drive_reg;

    // -------------------------------------------------------------
    // Crossings into the core domain
    // -------------------------------------------------------------
    tws_sync #(.WIDTH(3)) u_core_sync (
        .clk_in(clock_in),
        .rst_n_in(rst_n_in),
        .d_in({link_reg.req_tgl, stop_tgl_reg, write_protect_in}),
        .q_out(core_sync)
    );

    assign req_sync = core_sync[2];
    assign stop_sync = core_sync[1];
    assign wp_sync = core_sync[0]; // Open pin pulled low by its pad
    assign req_pending = (req_sync != core_reg.req_seen);
    assign stop_evt = (stop_sync != core_reg.stop_last);

    // -------------------------------------------------------------
    // Write buffer
    // -------------------------------------------------------------
    // Request payload is stable from its toggle until acknowledged
    assign push_entry = tws_wr_entry_s'({link_reg.req_addr,
                                         link_reg.req_data});
    assign fifo_bus.push_valid = req_pending && link_reg.req_wr;
    assign fifo_bus.push_data = push_entry;
    assign fifo_bus.pop_ready = !core_reg.busy;
    assign pop_entry = tws_wr_entry_s'(fifo_bus.pop_data);
    assign pop_take = fifo_bus.pop_valid && fifo_bus.pop_ready;

    tws_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clock_in),
        .rst_n_in(rst_n_in),
        .port(fifo_bus)
    );

    // -------------------------------------------------------------
    // Core control
    // -------------------------------------------------------------
    assign copy_wr = core_reg.busy && core_reg.copy_idx != COPY_END &&
                     core_reg.mask[core_reg.copy_idx[6:0]];

    // Request intake, page latch, stop handling and programming timer
    always_comb begin
        core_next = core_reg;
        core_next.stop_last = stop_sync;
        if (req_pending && (!link_reg.req_wr || fifo_bus.push_ready)) begin
            core_next.req_seen = ~core_reg.req_seen;
            if (link_reg.req_wr) begin
                // Current address follows the written byte in-page
                core_next.rd_addr = {link_reg.req_addr[15:7],
                                     link_reg.req_addr[6:0] + 7'h01};
            end else begin
                core_next.rd_addr = link_reg.req_addr;
            end
        end
        if (pop_take) begin
            // Only the bytes actually sent get programmed
            core_next.mask[pop_entry.offs] = 1'b1;
            core_next.page = pop_entry.page;
        end
        if (core_reg.stop_pend && !req_pending && !fifo_bus.pop_valid &&
            !core_reg.busy) begin
            core_next.stop_pend = 1'b0;
            if (core_reg.mask != '0 && !wp_sync) begin
                core_next.busy = 1'b1;
                core_next.timer = TIMER_W'(PROG_CYCLES_P - 1);
                core_next.copy_idx = 8'h00;
            end else begin
                // Protected or address-only write: discard the page
                core_next.mask = '0;
            end
        end
        if (core_reg.busy) begin
            if (core_reg.copy_idx != COPY_END) begin
                core_next.copy_idx = core_reg.copy_idx + 8'h01;
            end
            if (core_reg.timer != '0) begin
                core_next.timer = core_reg.timer - 1'b1;
            end else if (core_reg.copy_idx == COPY_END) begin
                core_next.busy = 1'b0;
                core_next.mask = '0;
            end
        end
        // A stop in the same cycle as the clear above still counts
        if (stop_evt) begin
            core_next.stop_pend = 1'b1;
        end
    end

    // Core state register
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_reg <= CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    // -------------------------------------------------------------
    // Array and page latch
    // -------------------------------------------------------------
    // Read byte is prefetched a whole word time before the link
    // loads it, so the link sees a settled value.
    always_ff @(posedge clock_in) begin
        rd_byte_reg <= mem_array[core_reg.rd_addr];
        if (pop_take) begin
            page_latch[pop_entry.offs] <= pop_entry.data;
        end
        if (copy_wr) begin
            mem_array[{core_reg.page, core_reg.copy_idx[6:0]}] <=
                page_latch[core_reg.copy_idx[6:0]];
        end
    end

    assign program_busy_out = core_reg.busy;

endmodule // tws_target

// [verif/tws_target_assertions.sv]
// Port checks on the two-wire memory target
`timescale 1ns/10ps
module tws_target_chk
    import tws_pkg::*;
#(parameter int unsigned PROG_CYCLES_P = PROG_CYCLES) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    // Straps and status
    input wire logic [2:0] device_select_inputs_in,
    input wire logic write_protect_in,
    input wire logic program_busy_out
);
    // Page copy alone needs 129 cycles, so busy is never shorter
    localparam int BMIN = (PROG_CYCLES_P > 129) ? PROG_CYCLES_P : 129;
    localparam int BLO = BMIN - 1;
    localparam int BHI = BMIN + 2;
    logic [TIMER_W-1:0] len_reg; // Cycles spent busy so far
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in)
            len_reg <= '0;
        else
            len_reg <= program_busy_out ? len_reg + 1'b1 : '0;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    property p_od; sda_out == 1'b0; endproperty
    a_od: assert property (p_od)
        else $error("data pin level not low");
    property p_chg; $changed(sda_oe_n_out) |-> !scl_in; endproperty
    a_chg: assert property (p_chg)
        else $error("data changed with clock high");
    property p_len; $fell(program_busy_out) |->
        len_reg >= BLO && len_reg <= BHI; endproperty
    a_len: assert property (p_len)
        else $error("programming time wrong");
    property p_wp; $rose(program_busy_out) |->
        !write_protect_in && !$past(write_protect_in, 8); endproperty
    a_wp: assert property (p_wp)
        else $error("programming while protected");
    property p_busy; program_busy_out |-> sda_oe_n_out; endproperty
    a_busy: assert property (p_busy)
        else $error("bus driven while programming");
    property p_rst; disable iff (1'b0)
        !rst_n_in |-> sda_oe_n_out && !program_busy_out; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs active in reset");
    property p_low; $fell(sda_oe_n_out) |-> !sda_oe_n_out [*3]; endproperty
    a_low: assert property (p_low)
        else $error("low bit shorter than a clock");
    property p_idle; $rose(program_busy_out) |-> scl_in && sda_in;
    endproperty
    a_idle: assert property (p_idle)
        else $error("programming began during a frame");
endmodule // tws_target_chk
bind tws_target tws_target_chk #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk_i (
    .clock_in, .rst_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
    .device_select_inputs_in, .write_protect_in, .program_busy_out);

// [verif/tws_master.sv]
// Bus master model; its clock stands high between frames
`timescale 1ns/10ps
module tws_master (
    // Link wires
    output logic scl_out,
    output logic rel_out,
    input wire logic sda_in
);
    logic [7:0] rx; // Last byte read
    event got; // A read byte is complete
    initial begin
        scl_out = 1'b1;
        rel_out = 1'b1;
    end
    // One 80 ns bit; data moves only in the low half
    task automatic bit_io(input logic b, output logic r);
        rel_out = b;
        #20 scl_out = 1'b1;
        #20 r = sda_in;
        #20 scl_out = 1'b0;
        #20;
    endtask
    task automatic start();
        #7 rel_out = 1'b1;
        #20 scl_out = 1'b1;
        #20 rel_out = 1'b0;
        #20 scl_out = 1'b0;
        #20;
    endtask
    // Bus free time keeps the next start well clear
    task automatic stop();
        rel_out = 1'b0;
        #20 scl_out = 1'b1;
        #20 rel_out = 1'b1;
        #200;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic more);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, rx[i]);
        bit_io(!more, r);
        -> got;
    endtask
endmodule // tws_master

// [verif/tws_target_tb.sv]
// Self-checking bench for the two-wire memory target
`timescale 1ns/10ps
module tws_target_tb;
    import tws_pkg::*;
    logic clock_in, rst_n_in, scl, rel, oe_n, sda_o, busy, wp, ack;
    logic [2:0] sel;
    logic [7:0] d [3];
    logic [7:0] exp_q [$]; // Bytes the reads must return
    int num_errors = 0, samples_checked = 0, seed = 32'he22d, cyc = 0;
    // Open-drain wire with pull-up
    tws_target #(.PROG_CYCLES_P(200)) tws_target_i (.clock_in, .rst_n_in,
        .scl_in(scl), .sda_in(oe_n & rel), .sda_out(sda_o),
        .sda_oe_n_out(oe_n), .device_select_inputs_in(sel),
        .write_protect_in(wp), .program_busy_out(busy));
    tws_master tws_master_i (.scl_out(scl), .rel_out(rel),
        .sda_in(oe_n & rel));
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 10000) begin
            num_errors++;
            conclude();
        end
    end
    always @(tws_master_i.got) chk(tws_master_i.rx, exp_q.pop_front());
    task automatic dev(input logic [7:0] a, input logic e);
        tws_master_i.start();
        tws_master_i.wbyte(a, ack);
        chk({7'h0, ack}, {7'h0, e});
    endtask
    task automatic wb(input logic [7:0] v);
        tws_master_i.wbyte(v, ack);
        chk({7'h0, ack}, 8'h01);
    endtask
    task automatic waddr(input logic [15:0] a);
        dev({4'ha, sel, 1'b0}, 1'b1);
        wb(a[15:8]);
        wb(a[7:0]);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        waddr(a);
        dev({4'ha, sel, 1'b1}, 1'b1);
        exp_q.push_back(e);
        if (a == 16'h017e) begin
            exp_q.push_back(d[1]);
            tws_master_i.rbyte(1'b1);
        end
        tws_master_i.rbyte(1'b0);
        tws_master_i.stop();
    endtask
    initial begin
        rst_n_in = 1'b1;
        #1 rst_n_in = 1'b0;
        wp = 1'b0;
        sel = 3'h0;
        repeat (4) @(posedge clock_in);
        #1 rst_n_in = 1'b1;
        chk({6'h0, busy, oe_n}, 8'h01);
        @(posedge clock_in) #1 sel = 3'($random(seed));
        for (int i = 0; i < 8; i++) begin
            dev({4'ha, i[2:0], 1'b0}, i[2:0] == sel);
            tws_master_i.stop();
        end
        dev({4'hb, sel, 1'b0}, 1'b0);
        tws_master_i.stop();
        $display("test addressing finished");
        waddr(16'h017e);
        for (int i = 0; i < 3; i++) begin
            d[i] = 8'($random(seed));
            wb(d[i]);
        end
        tws_master_i.stop();
        dev({4'ha, sel, 1'b0}, 1'b0);
        tws_master_i.stop();
        chk({7'h0, busy}, 8'h01);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge clock_in) #1;
        chk({7'h0, busy}, 8'h00);
        // Third byte must land back at the page start
        for (int i = 0; i < 3; i++) rd({9'h002, 7'h7e + 7'(i)}, d[i]);
        $display("test page write finished");
        @(posedge clock_in) #1 wp = 1'b1;
        waddr(16'h0100);
        wb(~d[2]);
        tws_master_i.stop();
        repeat (20) @(posedge clock_in) #1;
        chk({7'h0, busy}, 8'h00);
        @(posedge clock_in) #1 wp = 1'b0;
        rd(16'h0100, d[2]);
        $display("test protect finished");
        conclude();
    end
endmodule // tws_target_tb
